// [pkg/regfile_pkg.sv]
/*
  Constants and types for the register file address decoder.
  Assumes a 12-bit byte address and 8-bit data from the core.
*/
`default_nettype none
package regfile_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int RAM_DEPTH = 256;
  localparam int RAM_AW = 8;
  localparam logic [11:0] RAM_BASE = 12'h000;
  localparam logic [11:0] RAM_LAST = 12'h0FF;
  localparam logic [11:0] CTRL_BASE = 12'hF00;
  localparam logic [11:0] CTRL_LAST = 12'hFFF;
  localparam logic [11:0] TRIM_BIT_INDEX_OFS = 12'hFF6;
  localparam logic [11:0] TRIM_BIT_VALUE_OFS = 12'hFF7;
  localparam logic [11:0] FLASH_CMD_STAT_OFS = 12'hFF8;
  localparam logic [11:0] FLASH_PAGE_OFS = 12'hFF9;
  localparam logic [11:0] FLASH_RATE_HIGH_OFS = 12'hFFA;
  localparam logic [11:0] FLASH_RATE_LOW_OFS = 12'hFFB;
  localparam logic [11:0] CPU_FLAGS_OFS = 12'hFFC;
  localparam logic [11:0] WORKING_GROUP_OFS = 12'hFFD;
  localparam logic [11:0] STACK_TOP_HIGH_OFS = 12'hFFE;
  localparam logic [11:0] STACK_TOP_LOW_OFS = 12'hFFF;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] UNDEF_READ = 8'h00;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } rf_req_s;

  typedef enum logic [1:0] {
    REGION_RAM,
    REGION_HOLE,
    REGION_CTRL
  } region_e;
endpackage
`default_nettype wire

// [rtl/regfile_ram.sv]
/*
  256 x 8 general purpose register storage with registered read data.
  Assumes one access per cycle; write and read may share a cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module regfile_ram (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [0:regfile_pkg::RAM_DEPTH-1];

  // storage has no reset: contents are undefined after power-up
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule
`default_nettype wire

// [rtl/register_file_address_decode.sv]
/*
  Register file decoder: RAM at the bottom, control registers at the top.
  Assumes the core presents one request per cycle, synchronous to
  ref_clk_i, and takes read data two cycles after the read request.
*/
// Behaviour
// [RULE1] decode a 4096-byte space in two sections
// [RULE2] top 256 bytes F00-FFF are control registers
// [RULE3] unassigned control reads return don't-care data
// [RULE4] core should never write unassigned control addresses
// [RULE5] RAM from address zero, 256 bytes at most
// [RULE6] hole reads undefined, hole writes do nothing
// [RULE7] source operands read, destination operands written
// [RULE8] flash rate high FFA, low FFB, reset zero
// [RULE9] stop-mode droop detector chosen by option bit
// [RULE10] shared address: write command, read condition
`timescale 1ns/100ps
`default_nettype none
module register_file_address_decode (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire regfile_pkg::rf_req_s req_i,
  input wire logic [7:0] flash_condition_i,
  input wire logic droop_detector_in_stop_option_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [7:0] trim_bit_index_o,
  output logic [7:0] trim_bit_value_o,
  output logic [7:0] flash_command_o,
  output logic flash_command_wr_o,
  output logic [7:0] flash_page_choice_o,
  output logic [7:0] flash_sector_guard_o,
  output logic [15:0] flash_rate_o,
  output logic [7:0] cpu_flags_o,
  output logic [7:0] working_group_pointer_o,
  output logic [15:0] stack_top_o,
  output logic droop_detector_in_stop_o
);
  regfile_pkg::region_e region;
  logic in_ram, in_ctrl;
  logic wr_ram;
  logic sel_tidx, sel_tval, sel_fcs, sel_fpage, sel_frh, sel_frl;
  logic sel_flags, sel_wgp, sel_sph, sel_spl;
  logic wr_tidx, wr_tval, wr_fcmd, wr_page, wr_guard, wr_frh, wr_frl;
  logic wr_flags, wr_wgp, wr_sph, wr_spl;
  logic [7:0] ram_rdata;
  logic [7:0] ctrl_rdata;
  logic rd_ram_q, rd_ctrl_q;
  logic [7:0] ctrl_rdata_q;
  logic [7:0] trim_bit_index_q, trim_bit_value_q;
  logic [7:0] flash_command_q, flash_page_choice_q;
  logic [7:0] flash_sector_guard_q;
  logic [7:0] flash_rate_high_q, flash_rate_low_q;
  logic [7:0] cpu_flags_q, working_group_pointer_q;
  logic [7:0] stack_top_high_q, stack_top_low_q;
  logic flash_command_wr_q;
  logic guard_next_q;
  logic droop_opt_q;

  // full 12-bit address is decoded, no aliasing
  assign in_ram = req_i.addr <= regfile_pkg::RAM_LAST; // [RULE5]
  assign in_ctrl = req_i.addr >= regfile_pkg::CTRL_BASE; // [RULE2]
  assign region = in_ram ? regfile_pkg::REGION_RAM :
                  in_ctrl ? regfile_pkg::REGION_CTRL :
                  regfile_pkg::REGION_HOLE; // [RULE1]

  // hole writes reach no storage
  assign wr_ram = req_i.wr && (region == regfile_pkg::REGION_RAM); // [RULE6]

  assign sel_tidx = req_i.addr == regfile_pkg::TRIM_BIT_INDEX_OFS;
  assign sel_tval = req_i.addr == regfile_pkg::TRIM_BIT_VALUE_OFS;
  assign sel_fcs = req_i.addr == regfile_pkg::FLASH_CMD_STAT_OFS;
  assign sel_fpage = req_i.addr == regfile_pkg::FLASH_PAGE_OFS;
  assign sel_frh = req_i.addr == regfile_pkg::FLASH_RATE_HIGH_OFS;
  assign sel_frl = req_i.addr == regfile_pkg::FLASH_RATE_LOW_OFS;
  assign sel_flags = req_i.addr == regfile_pkg::CPU_FLAGS_OFS;
  assign sel_wgp = req_i.addr == regfile_pkg::WORKING_GROUP_OFS;
  assign sel_sph = req_i.addr == regfile_pkg::STACK_TOP_HIGH_OFS;
  assign sel_spl = req_i.addr == regfile_pkg::STACK_TOP_LOW_OFS;

  // write strobes per register; unassigned control writes hit none
  assign wr_tidx = req_i.wr && sel_tidx;
  assign wr_tval = req_i.wr && sel_tval;
  assign wr_fcmd = req_i.wr && sel_fcs; // [RULE10]
  assign wr_page = req_i.wr && sel_fpage && !guard_next_q;
  assign wr_guard = req_i.wr && sel_fpage && guard_next_q;
  assign wr_frh = req_i.wr && sel_frh; // [RULE8]
  assign wr_frl = req_i.wr && sel_frl; // [RULE8]
  assign wr_flags = req_i.wr && sel_flags; // [RULE7]
  assign wr_wgp = req_i.wr && sel_wgp;
  assign wr_sph = req_i.wr && sel_sph;
  assign wr_spl = req_i.wr && sel_spl;

  // read mux; unassigned control addresses fall to a fixed pattern
  assign ctrl_rdata =
    sel_tidx ? trim_bit_index_q :
    sel_tval ? trim_bit_value_q :
    sel_fcs ? flash_condition_i : // [RULE10]
    sel_fpage ? (guard_next_q ? flash_sector_guard_q
                              : flash_page_choice_q) :
    sel_frh ? flash_rate_high_q : // [RULE8]
    sel_frl ? flash_rate_low_q : // [RULE8]
    sel_flags ? cpu_flags_q :
    sel_wgp ? working_group_pointer_q :
    sel_sph ? stack_top_high_q :
    sel_spl ? stack_top_low_q :
    regfile_pkg::UNDEF_READ; // [RULE3]

  regfile_ram u_ram (
    .ref_clk_i(ref_clk_i),
    .we_i(wr_ram), // [RULE7]
    .waddr_i(req_i.addr[7:0]),
    .wdata_i(req_i.wdata),
    .raddr_i(req_i.addr[7:0]),
    .rdata_o(ram_rdata)
  );

  // read data steering, one cycle after the request
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rd_ram_q <= 1'b0;
      rd_ctrl_q <= 1'b0;
      ctrl_rdata_q <= regfile_pkg::ZERO_RST;
      rvalid_o <= 1'b0;
    end else begin
      rd_ram_q <= req_i.rd && (region == regfile_pkg::REGION_RAM);
      rd_ctrl_q <= req_i.rd && (region == regfile_pkg::REGION_CTRL);
      ctrl_rdata_q <= ctrl_rdata;
      rvalid_o <= req_i.rd; // [RULE7]
    end
  end

  // rdata_o must come from a flop, so RAM data is re-registered
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= regfile_pkg::ZERO_RST;
    end else if (rd_ram_q) begin
      rdata_o <= ram_rdata;
    end else if (rd_ctrl_q) begin
      rdata_o <= ctrl_rdata_q;
    end else begin
      rdata_o <= regfile_pkg::UNDEF_READ; // [RULE6]
    end
  end

  // trim and flash registers with a defined reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      trim_bit_index_q <= regfile_pkg::ZERO_RST;
    end else if (wr_tidx) begin
      trim_bit_index_q <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      flash_command_q <= regfile_pkg::ZERO_RST;
    end else if (wr_fcmd) begin
      flash_command_q <= req_i.wdata; // [RULE10]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      flash_command_wr_q <= 1'b0;
    end else begin
      flash_command_wr_q <= wr_fcmd; // [RULE10]
    end
  end

  // page and guard share one address; guard view follows a
  // command write of 8'h5E, any other command returns to page
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      guard_next_q <= 1'b0;
    end else if (wr_fcmd) begin
      guard_next_q <= req_i.wdata == 8'h5E;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      flash_page_choice_q <= regfile_pkg::ZERO_RST;
    end else if (wr_page) begin
      flash_page_choice_q <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      flash_sector_guard_q <= regfile_pkg::ZERO_RST;
    end else if (wr_guard) begin
      flash_sector_guard_q <= flash_sector_guard_q | req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      flash_rate_high_q <= regfile_pkg::ZERO_RST; // [RULE8]
    end else if (wr_frh) begin
      flash_rate_high_q <= req_i.wdata; // [RULE8]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      flash_rate_low_q <= regfile_pkg::ZERO_RST; // [RULE8]
    end else if (wr_frl) begin
      flash_rate_low_q <= req_i.wdata; // [RULE8]
    end
  end

  // core registers reset undefined; cleared anyway for clean outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      trim_bit_value_q <= regfile_pkg::ZERO_RST;
    end else if (wr_tval) begin
      trim_bit_value_q <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cpu_flags_q <= regfile_pkg::ZERO_RST;
    end else if (wr_flags) begin
      cpu_flags_q <= req_i.wdata; // [RULE7]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      working_group_pointer_q <= regfile_pkg::ZERO_RST;
    end else if (wr_wgp) begin
      working_group_pointer_q <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      stack_top_high_q <= regfile_pkg::ZERO_RST;
    end else if (wr_sph) begin
      stack_top_high_q <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      stack_top_low_q <= regfile_pkg::ZERO_RST;
    end else if (wr_spl) begin
      stack_top_low_q <= req_i.wdata;
    end
  end

  // option bit is resampled every cycle after reset release, never written by software
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      droop_opt_q <= 1'b0;
    end else begin
      droop_opt_q <= droop_detector_in_stop_option_i; // [RULE9]
    end
  end

  // output copies, each straight from a flop
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      trim_bit_index_o <= regfile_pkg::ZERO_RST;
      trim_bit_value_o <= regfile_pkg::ZERO_RST;
    end else begin
      trim_bit_index_o <= trim_bit_index_q;
      trim_bit_value_o <= trim_bit_value_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      flash_command_o <= regfile_pkg::ZERO_RST;
      flash_command_wr_o <= 1'b0;
      flash_page_choice_o <= regfile_pkg::ZERO_RST;
      flash_sector_guard_o <= regfile_pkg::ZERO_RST;
      flash_rate_o <= 16'h0000;
    end else begin
      flash_command_o <= flash_command_q;
      flash_command_wr_o <= flash_command_wr_q;
      flash_page_choice_o <= flash_page_choice_q;
      flash_sector_guard_o <= flash_sector_guard_q;
      flash_rate_o <= {flash_rate_high_q, flash_rate_low_q};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cpu_flags_o <= regfile_pkg::ZERO_RST;
      working_group_pointer_o <= regfile_pkg::ZERO_RST;
      stack_top_o <= 16'h0000;
    end else begin
      cpu_flags_o <= cpu_flags_q;
      working_group_pointer_o <= working_group_pointer_q;
      stack_top_o <= {stack_top_high_q, stack_top_low_q};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      droop_detector_in_stop_o <= 1'b0;
    end else begin
      droop_detector_in_stop_o <= droop_opt_q; // [RULE9]
    end
  end
endmodule
`default_nettype wire

// [test/rf_decode_properties.sv]
/* Port checker for the register file decoder.
   Assumes a bind onto the decoder top and a single clock domain. */
`timescale 1ns/100ps
`default_nettype none
module rf_decode_properties (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire regfile_pkg::rf_req_s req_i,
  input wire logic droop_detector_in_stop_option_i,
  input wire logic rvalid_o,
  input wire logic [7:0] flash_command_o,
  input wire logic flash_command_wr_o,
  input wire logic [15:0] flash_rate_o,
  input wire logic [15:0] stack_top_o,
  input wire logic droop_detector_in_stop_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic [7:0] wd = req_i.wdata;
  wire logic w_cmd = req_i.wr && req_i.addr == 12'hFF8;
  wire logic w_hi = req_i.wr && req_i.addr == 12'hFFA;
  wire logic w_lo = req_i.wr && req_i.addr == 12'hFFB;
  wire logic w_sp = req_i.wr && req_i.addr == 12'hFFF;
  a_read_answers: assert property (req_i.rd |=> rvalid_o)
    else $error("read got no valid");
  a_valid_cause: assert property (rvalid_o |-> $past(req_i.rd))
    else $error("valid without read");
  a_rate_high: assert property (w_hi |=>
    ##1 flash_rate_o[15:8] == $past(wd, 2)) else $error("rate high");
  a_rate_low: assert property (w_lo |=>
    ##1 flash_rate_o[7:0] == $past(wd, 2)) else $error("rate low");
  a_stack_low: assert property (w_sp |=>
    ##1 stack_top_o[7:0] == $past(wd, 2)) else $error("stack low");
  a_cmd_pulse: assert property (w_cmd |=>
    ##1 flash_command_wr_o && flash_command_o == $past(wd, 2))
    else $error("no command pulse");
  a_pulse_cause: assert property (flash_command_wr_o |->
    $past(w_cmd, 2)) else $error("stray command pulse");
  a_option_copy: assert property (
    $stable(droop_detector_in_stop_option_i) [*3] |->
    droop_detector_in_stop_o == droop_detector_in_stop_option_i)
    else $error("option bit not followed");
  cover property (req_i.rd ##1 rvalid_o);
  cover property (w_cmd ##2 flash_command_wr_o);
  cover property ($rose(droop_detector_in_stop_o));
endmodule
`default_nettype wire

// [test/core_model.sv]
/* Core-side requester for the register file decoder.
   Assumes one-cycle rd/wr strobes and read data two edges later. */
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic ref_clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output var regfile_pkg::rf_req_s req_o
);
  initial req_o = '0;
  // released lines flip so stale values never look valid
  task automatic drop();
    req_o <= '{1'b0, 1'b0, ~req_o.addr, ~req_o.wdata};
  endtask
  // destination operand write; callers keep off unassigned control
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) req_o <= '{1'b0, 1'b1, a, d};
    @(posedge ref_clk_i) drop();
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    int n;
    @(posedge ref_clk_i) req_o <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge ref_clk_i) drop();
    for (n = 0; n < 4 && rvalid_i !== 1'b1; n++) @(posedge ref_clk_i);
    d = 'x;
    if (n < 4) @(posedge ref_clk_i) d = rdata_i;
  endtask
endmodule
`default_nettype wire

// [test/register_file_address_decode_tb.sv]
/* Self-checking bench for the register file decoder.
   Assumes core_model as requester and the checker bound below. */
`timescale 1ns/100ps
`default_nettype none
module register_file_address_decode_tb;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] flash_condition_i = 8'h00;
  logic droop_detector_in_stop_option_i = 1'b0;
  regfile_pkg::rf_req_s req;
  logic [7:0] rdata, cmd, pg, guard, flags, wgp, tbi, tbv, d, gv;
  logic rvalid, cmd_wr, droop;
  logic [15:0] rate, stack;
  logic [11:0] a;
  logic [31:0] seed = 32'h09CBA02A;
  logic [7:0] shadow [logic [11:0]];
  int n_errors = 0;
  int comparisons = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  core_model core (.ref_clk_i(ref_clk_i), .rvalid_i(rvalid),
    .rdata_i(rdata), .req_o(req));
  register_file_address_decode DUT (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .req_i(req), .flash_condition_i(flash_condition_i),
    .droop_detector_in_stop_option_i(droop_detector_in_stop_option_i),
    .rdata_o(rdata), .rvalid_o(rvalid), .trim_bit_index_o(tbi),
    .trim_bit_value_o(tbv), .flash_command_o(cmd),
    .flash_command_wr_o(cmd_wr), .flash_page_choice_o(pg),
    .flash_sector_guard_o(guard), .flash_rate_o(rate), .cpu_flags_o(flags),
    .working_group_pointer_o(wgp), .stack_top_o(stack),
    .droop_detector_in_stop_o(droop));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // status is read at the command address, holes read as zero
  function automatic logic [7:0] exp_rd(logic [11:0] x);
    if (x == 12'hFF8) return flash_condition_i;
    if (shadow.exists(x)) return shadow[x];
    return 8'h00;
  endfunction
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic put(logic [11:0] x, logic [7:0] v);
    core.wr(x, v);
    if (x <= 12'h0FF || (x >= 12'hFF6 && x != 12'hFF8)) shadow[x] = v;
  endtask
  task automatic get(logic [11:0] x);
    logic [7:0] v;
    core.rd(x, v);
    chk($sformatf("read %h", x), {8'h00, exp_rd(x)}, {8'h00, v});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    n_errors++;
    conclude();
  end
  initial begin
    for (int i = 0; i < 10; i++) if (i != 2) shadow[12'hFF6 + i[11:0]] = 8'h00;
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    chk("rate", 16'h0000, rate);
    for (int i = 0; i < 10; i++) get(12'hFF6 + i[11:0]);
    $display("reset values done");
    for (int i = 0; i < 14; i++) begin
      a = (i < 2) ? {4'h0, {8{i[0]}}} : {4'h0, rnd()};
      put(a, rnd());
      put({4'h1 + i[3:0], a[7:0]}, rnd());
      get(a);
      get({4'h1 + i[3:0], a[7:0]});
      get({5'h1E, a[6:0]});
    end
    $display("ram and hole done");
    for (int i = 0; i < 10; i++) begin
      a = 12'hFF6 + i[11:0];
      flash_condition_i <= rnd();
      put(a, (i == 2) ? 8'hA5 : rnd());
      get(a);
    end
    chk("rate", {shadow[12'hFFA], shadow[12'hFFB]}, rate);
    chk("stack", {shadow[12'hFFE], shadow[12'hFFF]}, stack);
    chk("trim", {shadow[12'hFF6], shadow[12'hFF7]}, {tbi, tbv});
    chk("command", 16'h00A5, {8'h00, cmd});
    chk("flags", {shadow[12'hFFC], shadow[12'hFFD]}, {flags, wgp});
    $display("control registers done");
    // a 5E command turns FF9 into the sticky guard bits
    gv = rnd();
    put(12'hFF8, 8'h5E);
    core.wr(12'hFF9, gv);
    core.wr(12'hFF9, 8'h01);
    core.rd(12'hFF9, d);
    chk("guard read", {8'h00, gv | 8'h01}, {8'h00, d});
    chk("guard", {8'h00, gv | 8'h01}, {8'h00, guard});
    put(12'hFF8, 8'h00);
    get(12'hFF9);
    chk("page", {8'h00, shadow[12'hFF9]}, {8'h00, pg});
    $display("guard view done");
    for (int i = 0; i < 4; i++) begin
      droop_detector_in_stop_option_i <= i[0];
      repeat (3) @(posedge ref_clk_i);
      chk("option", {15'h0000, i[0]}, {15'h0000, droop});
    end
    $display("option bit done");
    conclude();
  end
endmodule
bind register_file_address_decode rf_decode_properties chk_i (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
  .droop_detector_in_stop_option_i(droop_detector_in_stop_option_i),
  .rvalid_o(rvalid_o), .flash_command_o(flash_command_o),
  .flash_command_wr_o(flash_command_wr_o), .flash_rate_o(flash_rate_o),
  .stack_top_o(stack_top_o),
  .droop_detector_in_stop_o(droop_detector_in_stop_o));
`default_nettype wire
